//--- itcd_pkg.sv
/*
 * itcd_pkg: constants shared by the input terminal command decoder.
 * Assumes: used by qualified name only, never imported.
 */
package itcd_pkg;

   // terminal assignment codes
   localparam int CODE_W = 11;
   localparam logic [10:0] CODE_NEG_OFFSET = 11'h3E8; // active-low codes sit this far up
   localparam logic [10:0] CODE_STEP_B0 = 11'h000;
   localparam logic [10:0] CODE_STEP_B1 = 11'h001;
   localparam logic [10:0] CODE_STEP_B2 = 11'h002;
   localparam logic [10:0] CODE_STEP_B3 = 11'h003;
   localparam logic [10:0] CODE_RAMP = 11'h004;
   localparam logic [10:0] CODE_HOLD = 11'h006;
   localparam logic [10:0] CODE_COAST = 11'h007;
   localparam logic [10:0] CODE_ALM_RST = 11'h008;
   localparam logic [10:0] CODE_TRIP = 11'h009;
   localparam logic [10:0] CODE_JOG = 11'h00A;
   localparam logic [10:0] CODE_FWD = 11'h062;
   localparam logic [10:0] CODE_REV = 11'h063;

   // internal command slots
   localparam int NSLOT = 12;
   localparam int SL_STEP0 = 0;
   localparam int SL_RAMP = 4;
   localparam int SL_HOLD = 5;
   localparam int SL_COAST = 6;
   localparam int SL_RST = 7;
   localparam int SL_TRIP = 8;
   localparam int SL_JOG = 9;
   localparam int SL_FWD = 10;
   localparam int SL_REV = 11;

   // terminals: three general purpose, then the two run terminals
   localparam int NTERM = 5;
   localparam int T_FWD = 3;
   localparam int T_REV = 4;

   // register map (byte addresses)
   localparam logic [7:0] REG_ASSIGN_FIRST = 8'h00;
   localparam logic [7:0] REG_ASSIGN_LAST = 8'h10;
   localparam logic [7:0] REG_CTRL = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;

   // reset assignment codes, all active-high
   localparam logic [10:0] RST_CODE_X1 = 11'h000;
   localparam logic [10:0] RST_CODE_X2 = 11'h001;
   localparam logic [10:0] RST_CODE_X3 = 11'h002;

   // control register: run source setting field
   localparam int CTRL_SRC_LSB = 0;
   localparam logic [1:0] RUN_SRC_RESET = 2'h0;
   localparam logic [1:0] RUN_SRC_DIGITAL = 2'h1;

   // status register fields
   localparam int ST_IDX_LSB = 0;
   localparam int ST_USE_PRESET = 4;
   localparam int ST_RAMP2 = 5;
   localparam int ST_FWD = 6;
   localparam int ST_REV = 7;
   localparam int ST_DISABLE = 8;
   localparam int ST_TRIP = 9;
   localparam int ST_ALARM = 10;
   localparam int ST_DISPLAY = 11;
   localparam int ST_JOG = 12;
   localparam int ST_LVL_LSB = 16;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {ITCD_NORMAL, ITCD_JOG_READY} itcd_jog_state_t;

endpackage

//--- itcd_decoder.sv
/*
 * itcd_decoder: programmable digital input terminal decoder with an
 * AXI4-Lite register slave for the assignment codes and run source setting.
 * Assumes: terminal pins are asynchronous to clk_i; the keypad toggle pulse
 * and all bus signals are on clk_i.
 */
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - code plus 1000 gives active-low variant
// - no active-low for run codes
// - run codes only on run terminals
// - trip code 9 fires OFF, 1009 ON
// - four step bits form binary preset index
// - index zero uses normal frequency source
// - ramp select OFF set one, ON two
// - unassigned ramp select means set one
// - run hold latches first run edge
// - hold OFF clears; unassigned means 2-wire
// - coast stop disables output, no alarm
// - reset ON clears alarm, OFF clears display
// - trip disables output, shows code, alarms
// - trip stays latched until alarm reset
// - jog input selects ready-for-jogging state
// - keypad source: keys toggle when jog OFF
// - digital source: jog input only, keys ignored
// - five terminals each carry assignment code
// - reset codes are all active-high
module itcd_decoder #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // terminal pins
   input wire logic [2:0] gp_in_i,
   input wire logic run_forward_i,
   input wire logic run_backward_i,
   input wire logic keypad_jog_toggle_i,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // decoded commands to the drive
   output logic [3:0] preset_index_o,
   output logic use_preset_o,
   output logic ramp_set_two_o,
   output logic run_fwd_o,
   output logic run_rev_o,
   output logic output_disable_o,
   output logic trip_latched_o,
   output logic alarm_relay_out_o,
   output logic ext_alarm_display_o,
   output logic jog_ready_o
);

   if (ADDR_W < 8) begin : g_chk
      $error("itcd_decoder: ADDR_W must be at least 8");
   end

   logic [itcd_pkg::CODE_W-1:0] assign_code [itcd_pkg::NTERM];
   logic [1:0] run_src;
   logic [itcd_pkg::NTERM-1:0] pins, s1, s2, s3, lvl;
   logic [itcd_pkg::NSLOT-1:0] hit [itcd_pkg::NTERM];
   logic [itcd_pkg::NSLOT-1:0] asg [itcd_pkg::NTERM];
   logic [itcd_pkg::NSLOT-1:0] cmd, cmd_asg, cmd_prev;
   logic lat_fwd, lat_rev, next_lat_fwd, next_lat_rev;
   itcd_pkg::itcd_jog_state_t jog_state, next_jog_state;
   logic rst_rise, rst_fall, fwd_rise, rev_rise;
   logic wr_go, rd_go;
   logic [31:0] status_word, rd_word;

   assign pins = {run_backward_i, run_forward_i, gp_in_i};

   // map one assignment code to a one-hot slot; run codes only on run terminals
   function automatic logic [itcd_pkg::NSLOT-1:0] slot_of(
      input logic [itcd_pkg::CODE_W-1:0] code,
      input logic run_term
   );
      logic neg;
      logic [itcd_pkg::CODE_W-1:0] base;
      logic [itcd_pkg::NSLOT-1:0] oh;
      neg = (code >= itcd_pkg::CODE_NEG_OFFSET);
      base = neg ? code - itcd_pkg::CODE_NEG_OFFSET : code;
      oh = '0;
      // unlisted codes fall through to no command
      case (base)
         itcd_pkg::CODE_STEP_B0: oh[itcd_pkg::SL_STEP0] = 1'b1;
         itcd_pkg::CODE_STEP_B1: oh[itcd_pkg::SL_STEP0 + 1] = 1'b1;
         itcd_pkg::CODE_STEP_B2: oh[itcd_pkg::SL_STEP0 + 2] = 1'b1;
         itcd_pkg::CODE_STEP_B3: oh[itcd_pkg::SL_STEP0 + 3] = 1'b1;
         itcd_pkg::CODE_RAMP: oh[itcd_pkg::SL_RAMP] = 1'b1;
         itcd_pkg::CODE_HOLD: oh[itcd_pkg::SL_HOLD] = 1'b1;
         itcd_pkg::CODE_COAST: oh[itcd_pkg::SL_COAST] = 1'b1;
         itcd_pkg::CODE_ALM_RST: oh[itcd_pkg::SL_RST] = 1'b1;
         itcd_pkg::CODE_TRIP: oh[itcd_pkg::SL_TRIP] = 1'b1;
         itcd_pkg::CODE_JOG: oh[itcd_pkg::SL_JOG] = 1'b1;
         // run codes: active-high only, run terminals only
         itcd_pkg::CODE_FWD: oh[itcd_pkg::SL_FWD] = run_term & ~neg;
         itcd_pkg::CODE_REV: oh[itcd_pkg::SL_REV] = run_term & ~neg;
         default: oh = '0;
      endcase
      return oh;
   endfunction

   // per terminal: three-stage synchroniser, settled level, polarity, decode
   for (genvar t = 0; t < itcd_pkg::NTERM; t++) begin : g_term
      logic act;
      logic [itcd_pkg::NSLOT-1:0] oh;
      // accept a change only once stages two and three agree
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            s1[t] <= 1'b0;
            s2[t] <= 1'b0;
            s3[t] <= 1'b0;
            lvl[t] <= 1'b0;
         end else begin
            s1[t] <= pins[t];
            s2[t] <= s1[t];
            s3[t] <= s2[t];
            if (s2[t] == s3[t]) begin
               lvl[t] <= s3[t];
            end
         end
      end
      assign oh = slot_of(assign_code[t], (t == itcd_pkg::T_FWD) || (t == itcd_pkg::T_REV));
      // codes at or above the offset invert the terminal level
      assign act = lvl[t] ^ (assign_code[t] >= itcd_pkg::CODE_NEG_OFFSET);
      assign asg[t] = oh;
      // trip is fail-safe: plain code fires when the terminal is OFF
      always_comb begin
         hit[t] = oh & {itcd_pkg::NSLOT{act}};
         hit[t][itcd_pkg::SL_TRIP] = oh[itcd_pkg::SL_TRIP] & ~act;
      end
   end

   // a command is on when any terminal carrying it is active; trip is on when one is inactive
   always_comb begin
      cmd = '0;
      cmd_asg = '0;
      for (int t = 0; t < itcd_pkg::NTERM; t++) begin
         cmd = cmd | hit[t];
         cmd_asg = cmd_asg | asg[t];
      end
   end

   // previous decoded commands for edge detection
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_prev <= '0;
      end else begin
         cmd_prev <= cmd;
      end
   end

   assign rst_rise = cmd[itcd_pkg::SL_RST] & ~cmd_prev[itcd_pkg::SL_RST];
   assign rst_fall = ~cmd[itcd_pkg::SL_RST] & cmd_prev[itcd_pkg::SL_RST];
   assign fwd_rise = cmd[itcd_pkg::SL_FWD] & ~cmd_prev[itcd_pkg::SL_FWD];
   assign rev_rise = cmd[itcd_pkg::SL_REV] & ~cmd_prev[itcd_pkg::SL_REV];

   // self-hold: first run edge while hold is on, cleared by hold off
   always_comb begin
      next_lat_fwd = lat_fwd;
      next_lat_rev = lat_rev;
      if (!cmd[itcd_pkg::SL_HOLD]) begin
         next_lat_fwd = 1'b0;
         next_lat_rev = 1'b0;
      end else if (!lat_fwd && !lat_rev) begin
         next_lat_fwd = fwd_rise;
         next_lat_rev = rev_rise & ~fwd_rise; // forward wins a tie
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lat_fwd <= 1'b0;
         lat_rev <= 1'b0;
      end else begin
         lat_fwd <= next_lat_fwd;
         lat_rev <= next_lat_rev;
      end
   end

   // run, speed and ramp outputs; in two-wire mode both directions at once means neither
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         run_fwd_o <= 1'b0;
         run_rev_o <= 1'b0;
         preset_index_o <= 4'h0;
         use_preset_o <= 1'b0;
         ramp_set_two_o <= 1'b0;
      end else begin
         // two-wire when no terminal carries hold
         if (cmd_asg[itcd_pkg::SL_HOLD]) begin
            run_fwd_o <= next_lat_fwd;
            run_rev_o <= next_lat_rev;
         end else begin
            run_fwd_o <= cmd[itcd_pkg::SL_FWD] & ~cmd[itcd_pkg::SL_REV];
            run_rev_o <= cmd[itcd_pkg::SL_REV] & ~cmd[itcd_pkg::SL_FWD];
         end
         // weights 8,4,2,1; zero keeps the normal source
         preset_index_o <= cmd[itcd_pkg::SL_STEP0 +: 4];
         use_preset_o <= |cmd[itcd_pkg::SL_STEP0 +: 4];
         // unassigned slot never decodes on, so set one holds
         ramp_set_two_o <= cmd[itcd_pkg::SL_RAMP];
      end
   end

   // trip latch and alarm; a trip in the reset cycle wins over the clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         trip_latched_o <= 1'b0;
         alarm_relay_out_o <= 1'b0;
         ext_alarm_display_o <= 1'b0;
         output_disable_o <= 1'b0;
      end else begin
         // trip sets the latch, relay and display
         if (cmd[itcd_pkg::SL_TRIP]) begin
            trip_latched_o <= 1'b1;
            alarm_relay_out_o <= 1'b1;
            ext_alarm_display_o <= 1'b1;
         end else begin
            // reset edge clears relay and latch, release clears display
            if (rst_rise) begin
               trip_latched_o <= 1'b0;
               alarm_relay_out_o <= 1'b0;
            end
            if (rst_fall) begin
               ext_alarm_display_o <= 1'b0;
            end
         end
         // coast stop only disables output, raises nothing
         output_disable_o <= cmd[itcd_pkg::SL_COAST] | cmd[itcd_pkg::SL_TRIP]
            | (trip_latched_o & ~rst_rise);
      end
   end

   always_comb begin
      next_jog_state = jog_state;
      if (cmd[itcd_pkg::SL_JOG]) begin
         next_jog_state = itcd_pkg::ITCD_JOG_READY;
      end else if (run_src == itcd_pkg::RUN_SRC_DIGITAL) begin
         next_jog_state = itcd_pkg::ITCD_NORMAL;
      end else if (keypad_jog_toggle_i) begin
         case (jog_state)
            itcd_pkg::ITCD_NORMAL: next_jog_state = itcd_pkg::ITCD_JOG_READY;
            itcd_pkg::ITCD_JOG_READY: next_jog_state = itcd_pkg::ITCD_NORMAL;
            default: next_jog_state = itcd_pkg::ITCD_NORMAL;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         jog_state <= itcd_pkg::ITCD_NORMAL;
         jog_ready_o <= 1'b0;
      end else begin
         jog_state <= next_jog_state;
         jog_ready_o <= (next_jog_state == itcd_pkg::ITCD_JOG_READY);
      end
   end

   // bus handshakes: one write and one read in flight, answered next cycle
   assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
   assign s_axi_awready_o = wr_go;
   assign s_axi_wready_o = wr_go;
   assign rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;
   assign s_axi_arready_o = rd_go;

   // byte-lane merge so partial writes keep untouched lanes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = d[8*b +: 8];
         end
      end
      return r;
   endfunction

   // writable assignment codes and run source, reset active-high
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         assign_code[0] <= itcd_pkg::RST_CODE_X1;
         assign_code[1] <= itcd_pkg::RST_CODE_X2;
         assign_code[2] <= itcd_pkg::RST_CODE_X3;
         assign_code[itcd_pkg::T_FWD] <= itcd_pkg::CODE_FWD;
         assign_code[itcd_pkg::T_REV] <= itcd_pkg::CODE_REV;
         run_src <= itcd_pkg::RUN_SRC_RESET;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= itcd_pkg::RESP_OKAY;
      end else begin
         if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= itcd_pkg::RESP_SLVERR;
            for (int t = 0; t < itcd_pkg::NTERM; t++) begin
               if (s_axi_awaddr_i[7:0] == itcd_pkg::REG_ASSIGN_FIRST + 8'(4 * t)) begin
                  assign_code[t] <= itcd_pkg::CODE_W'(merge(32'(assign_code[t]),
                     s_axi_wdata_i, s_axi_wstrb_i));
                  s_axi_bresp_o <= itcd_pkg::RESP_OKAY;
               end
            end
            if (s_axi_awaddr_i[7:0] == itcd_pkg::REG_CTRL) begin
               if (s_axi_wstrb_i[0]) begin
                  run_src <= s_axi_wdata_i[itcd_pkg::CTRL_SRC_LSB +: 2];
               end
               s_axi_bresp_o <= itcd_pkg::RESP_OKAY;
            end
            if (s_axi_awaddr_i[7:0] == itcd_pkg::REG_STATUS) begin
               s_axi_bresp_o <= itcd_pkg::RESP_OKAY; // read-only, write ignored
            end
            if (s_axi_awaddr_i[ADDR_W-1:0] != ADDR_W'(s_axi_awaddr_i[7:0])) begin
               s_axi_bresp_o <= itcd_pkg::RESP_SLVERR;
            end
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // status word shows decoded state and settled terminal levels
   always_comb begin
      status_word = '0;
      status_word[itcd_pkg::ST_IDX_LSB +: 4] = preset_index_o;
      status_word[itcd_pkg::ST_USE_PRESET] = use_preset_o;
      status_word[itcd_pkg::ST_RAMP2] = ramp_set_two_o;
      status_word[itcd_pkg::ST_FWD] = run_fwd_o;
      status_word[itcd_pkg::ST_REV] = run_rev_o;
      status_word[itcd_pkg::ST_DISABLE] = output_disable_o;
      status_word[itcd_pkg::ST_TRIP] = trip_latched_o;
      status_word[itcd_pkg::ST_ALARM] = alarm_relay_out_o;
      status_word[itcd_pkg::ST_DISPLAY] = ext_alarm_display_o;
      status_word[itcd_pkg::ST_JOG] = jog_ready_o;
      status_word[itcd_pkg::ST_LVL_LSB +: itcd_pkg::NTERM] = lvl;
   end

   // read mux; unmapped reads answer zero with an error
   always_comb begin
      rd_word = '0;
      for (int t = 0; t < itcd_pkg::NTERM; t++) begin
         if (s_axi_araddr_i[7:0] == itcd_pkg::REG_ASSIGN_FIRST + 8'(4 * t)) begin
            rd_word = 32'(assign_code[t]);
         end
      end
      if (s_axi_araddr_i[7:0] == itcd_pkg::REG_CTRL) begin
         rd_word = 32'(run_src);
      end
      if (s_axi_araddr_i[7:0] == itcd_pkg::REG_STATUS) begin
         rd_word = status_word;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= 32'h0000_0000;
         s_axi_rresp_o <= itcd_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid_o <= 1'b1;
         s_axi_rdata_o <= rd_word;
         s_axi_rresp_o <= (s_axi_araddr_i[ADDR_W-1:0] == ADDR_W'(s_axi_araddr_i[7:0])
            && s_axi_araddr_i[7:0] <= itcd_pkg::REG_STATUS && s_axi_araddr_i[1:0] == 2'h0)
            ? itcd_pkg::RESP_OKAY : itcd_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end
   end

   a_trip_alarm: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd[itcd_pkg::SL_TRIP] |=> alarm_relay_out_o && ext_alarm_display_o && output_disable_o)
      else $error("trip did not raise alarm and disable");
   a_trip_held: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      trip_latched_o && !rst_rise |=> trip_latched_o)
      else $error("trip latch dropped without reset");
   a_coast_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd[itcd_pkg::SL_COAST] && !alarm_relay_out_o && !cmd[itcd_pkg::SL_TRIP]
      |=> output_disable_o && !alarm_relay_out_o)
      else $error("coast stop misbehaved");
   a_reset_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rst_rise && !cmd[itcd_pkg::SL_TRIP] |=> !alarm_relay_out_o && !trip_latched_o)
      else $error("alarm reset did not clear relay");
   a_display_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rst_fall && !cmd[itcd_pkg::SL_TRIP] |=> !ext_alarm_display_o)
      else $error("display not cleared on reset release");
   a_preset_step: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ##1 preset_index_o == $past(cmd[itcd_pkg::SL_STEP0 +: 4])
      && use_preset_o == (preset_index_o != 4'h0))
      else $error("preset index mismatch");
   a_ramp_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !cmd_asg[itcd_pkg::SL_RAMP] ##1 !cmd_asg[itcd_pkg::SL_RAMP] |-> !ramp_set_two_o)
      else $error("ramp set two without assignment");
   a_hold_keeps: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd_asg[itcd_pkg::SL_HOLD] && cmd[itcd_pkg::SL_HOLD] && lat_fwd |=> run_fwd_o)
      else $error("held forward run lost");
   a_hold_release: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      cmd_asg[itcd_pkg::SL_HOLD] && !cmd[itcd_pkg::SL_HOLD] |=> !run_fwd_o && !run_rev_o)
      else $error("run persisted after hold off");
   a_digital_jog: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      run_src == itcd_pkg::RUN_SRC_DIGITAL |=> jog_ready_o == $past(cmd[itcd_pkg::SL_JOG]))
      else $error("digital source jog mismatch");

endmodule

//--- itcd_switch_model.sv
/*
 * itcd_switch_model: external switches wired to the five terminal pins.
 * Assumes: the bench names the wanted contact levels; contacts move
 * just after a clock edge, and the pins are open (all OFF) from the
 * first clock edge, well inside the bench's reset.
 */
`timescale 1ns/1ps
module itcd_switch_model (
   // clock and wanted levels {rev, fwd, x3, x2, x1}
   input wire logic clk_i,
   input wire logic [4:0] want_i,
   // terminal pins
   output logic [2:0] gp_o,
   output logic fwd_o,
   output logic rev_o
);
   logic [4:0] contact;
   // reset contact held
   // a level stands until the bench asks again, so no pulse is cut short
   always_ff @(posedge clk_i) begin
      contact <= want_i;
   end
   // contacts to pins
   assign {rev_o, fwd_o, gp_o} = contact;
endmodule

//--- tb_input_terminal_command_decoder.sv
/*
 * tb_input_terminal_command_decoder: bus and terminal sequences with
 * expected values. Assumes: 20 MHz clock, decode settles within 8 edges.
 */
`timescale 1ns/1ps
module tb_input_terminal_command_decoder;
   logic clk_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic [4:0] lv = 5'h00;
   logic kp = 1'h0;
   logic [2:0] gp;
   logic run_forward, run_backward, awr, wr, bv, arr, rv;
   logic [7:0] awa = 8'h00;
   logic [7:0] ara = 8'h00;
   logic [31:0] wd = 32'h0;
   logic awv = 1'h0;
   logic wv = 1'h0;
   logic arv = 1'h0;
   logic [1:0] br, rr;
   logic [31:0] rd;
   logic [3:0] pidx;
   logic upre, r2, rf, rb, dis, trp, alarm_relay_out, disp, jog;
   logic [31:0] rc [5] = '{32'h0, 32'h1, 32'h2, 32'h62, 32'h63};
   int n_errors = 0;
   int samples_checked = 0;
   // clock
   always #25 clk_i = ~clk_i;
   itcd_switch_model u_itcd_switch_model (.clk_i(clk_i), .want_i(lv), .gp_o(gp),
      .fwd_o(run_forward), .rev_o(run_backward));
   // response ready held high: a response is taken as soon as it shows
   itcd_decoder u_itcd_decoder (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .gp_in_i(gp),
      .run_forward_i(run_forward), .run_backward_i(run_backward), .keypad_jog_toggle_i(kp),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(1'h1), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(1'h1), .preset_index_o(pidx),
      .use_preset_o(upre), .ramp_set_two_o(r2), .run_fwd_o(rf), .run_rev_o(rb),
      .output_disable_o(dis), .trip_latched_o(trp), .alarm_relay_out_o(alarm_relay_out),
      .ext_alarm_display_o(disp), .jog_ready_o(jog));
   // verdict and end of run
   task automatic give_verdict;
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // one comparison
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded wait step
   task automatic guard(inout int n);
      n++;
      if (n > 40) begin
         chk("timeout", 32'h0, 32'h1);
         give_verdict();
      end
   endtask
   // bus write, address and data offered together
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      n = 0;
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin @(posedge clk_i); guard(n); end while (!(awr && wr));
      awv <= 1'h0;
      wv <= 1'h0;
      do begin @(posedge clk_i); guard(n); end while (!bv);
      chk("bresp", 32'(e), 32'(br));
   endtask
   // bus read
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      ara <= a;
      arv <= 1'h1;
      do begin @(posedge clk_i); guard(n); end while (!arr);
      arv <= 1'h0;
      do begin @(posedge clk_i); guard(n); end while (!rv);
      chk("rdata", e, rd);
      chk("rresp", 32'(er), 32'(rr));
   endtask
   // new contact levels, then the synchronised decode settles
   task automatic pins(input logic [4:0] v);
      lv <= v;
      repeat (8) @(posedge clk_i);
   endtask
   // keypad jog key combination, one cycle
   task automatic kpad;
      kp <= 1'h1;
      @(posedge clk_i);
      kp <= 1'h0;
      repeat (8) @(posedge clk_i);
   endtask
   // main sequence
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      for (int i = 0; i < 5; i++) axr(8'(i * 4), rc[i], 2'h0);
      axr(8'h14, 32'h0, 2'h0);
      axr(8'h1C, 32'h0, 2'h2);
      axw(8'h1C, 32'h1, 2'h2);
      pins(5'h05);
      chk("index", 32'h5, 32'(pidx));
      chk("use_preset", 32'h1, 32'(upre));
      axr(8'h18, 32'h0005_0015, 2'h0);
      pins(5'h00);
      chk("use_preset", 32'h0, 32'(upre));
      chk("ramp", 32'h0, 32'(r2));
      pins(5'h10);
      chk("run_rev", 32'h1, 32'(rb));
      pins(5'h08);
      chk("run_fwd", 32'h1, 32'(rf));
      chk("run_rev", 32'h0, 32'(rb));
      pins(5'h18);
      chk("run_fwd", 32'h0, 32'(rf));
      chk("run_rev", 32'h0, 32'(rb));
      pins(5'h08);
      axw(8'h08, 32'h3, 2'h0);
      pins(5'h04);
      chk("index", 32'h8, 32'(pidx));
      axw(8'h00, 32'h3E8, 2'h0);
      pins(5'h00);
      chk("index", 32'h1, 32'(pidx));
      axw(8'h00, 32'h62, 2'h0);
      pins(5'h01);
      chk("run_fwd", 32'h0, 32'(rf));
      axw(8'h0C, 32'h44A, 2'h0);
      pins(5'h08);
      chk("run_fwd", 32'h0, 32'(rf));
      pins(5'h00);
      axw(8'h0C, 32'h62, 2'h0);
      axw(8'h04, 32'h4, 2'h0);
      pins(5'h02);
      chk("ramp", 32'h1, 32'(r2));
      axw(8'h00, 32'h7, 2'h0);
      axw(8'h04, 32'h7, 2'h0);
      pins(5'h02);
      chk("disable", 32'h1, 32'(dis));
      chk("alarm", 32'h0, 32'(alarm_relay_out));
      pins(5'h01);
      chk("disable", 32'h1, 32'(dis));
      axw(8'h00, 32'h6, 2'h0);
      pins(5'h09);
      pins(5'h01);
      chk("run_fwd", 32'h1, 32'(rf));
      pins(5'h11);
      chk("run_rev", 32'h0, 32'(rb));
      pins(5'h00);
      chk("run_fwd", 32'h0, 32'(rf));
      pins(5'h02);
      axw(8'h04, 32'h9, 2'h0);
      pins(5'h02);
      chk("trip", 32'h0, 32'(trp));
      pins(5'h00);
      chk("trip", 32'h1, 32'(trp));
      chk("alarm", 32'h1, 32'(alarm_relay_out));
      chk("display", 32'h1, 32'(disp));
      chk("disable", 32'h1, 32'(dis));
      pins(5'h02);
      chk("trip", 32'h1, 32'(trp));
      axw(8'h08, 32'h8, 2'h0);
      pins(5'h06);
      chk("alarm", 32'h0, 32'(alarm_relay_out));
      chk("trip", 32'h0, 32'(trp));
      chk("display", 32'h1, 32'(disp));
      pins(5'h02);
      chk("display", 32'h0, 32'(disp));
      axw(8'h04, 32'h3F1, 2'h0);
      pins(5'h02);
      chk("trip", 32'h1, 32'(trp));
      pins(5'h04);
      pins(5'h00);
      chk("trip", 32'h0, 32'(trp));
      axw(8'h00, 32'hA, 2'h0);
      kpad();
      chk("jog", 32'h1, 32'(jog));
      kpad();
      chk("jog", 32'h0, 32'(jog));
      pins(5'h01);
      chk("jog", 32'h1, 32'(jog));
      axw(8'h14, 32'h1, 2'h0);
      pins(5'h00);
      chk("jog", 32'h0, 32'(jog));
      kpad();
      chk("jog", 32'h0, 32'(jog));
      axw(8'h14, 32'h3, 2'h0);
      kpad();
      chk("jog", 32'h1, 32'(jog));
      give_verdict();
   end
endmodule
